// ===== verilog/psc_top.sv
// Purpose : presence status command handler of the reader
// Assumes : commands arrive already decoded from the serial link
// Notes   : unknown codes get no reply here; other interpreters answer them
//
// Function
// - code 529 returns status: report flag, min period, rf-off, timeout, invert
// - report field 0 means presence reports without tag are disabled
// - minimum presence period field always reads zero milliseconds
// - rf-off field: 0 timeout, 1 timeout or tag, 2 timeout or no presence
// - timeout code 0 is zero milliseconds, always expired
// - codes 1 to 7 give 48 ms, or 150 ms in single truck mode
// - code 8 gives 60 ms, or 175 ms in single truck mode
// - code 9 gives 92 ms; single truck value is a constant to confirm
// - code A gives 152 ms, or 370 ms in single truck mode
// - code F never expires and is the reset value
// - invert field 0 when inversion off (reset), 1 when on
// - code 6901 enables presence reports without tag, answers Done
// - code 6900 disables presence reports without tag
// - codes 6920, 6921, 6922 select rf-off condition, each answers Done
`include "psc_regs.svh"

module psc_top #(
  parameter int MS_CYCLES = `PSC_MS_CYCLES
) (
  input  wire logic                 CORE_CLK_IN,
  input  wire logic                 RSTN_IN,
  input  wire psc_pkg::psc_cmd_s    CMD_IN,
  input  wire psc_pkg::psc_mode_e   MODE_IN,
  input  wire logic                 PRESENCE_PIN_IN,
  input  wire logic                 TAG_READ_IN,
  input  wire logic                 RF_ON_IN,
  input  wire logic                 CFG_LOAD_IN,
  input  wire logic [3:0]           CFG_TMO_CODE_IN,
  input  wire logic                 CFG_INVERT_IN,
  output logic                      REPLY_VALID_OUT,
  output psc_pkg::psc_kind_e        REPLY_KIND_OUT,
  output psc_pkg::psc_status_s      REPLY_STATUS_OUT,
  output logic                      PRESENCE_OUT,
  output logic                      PRESENCE_REPORT_OUT,
  output logic                      RF_OFF_REQ_OUT
);

  // ****************************************************************
  // presence pin synchroniser
  // ****************************************************************
  // pin is asynchronous to the core clock; nothing but the second flop reads the first
  logic pres_meta;
  logic pres_sync;

  always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      pres_meta <= 1'h0;
      pres_sync <= 1'h0;
    end else begin
      pres_meta <= PRESENCE_PIN_IN;
      pres_sync <= pres_meta;
    end
  end

  // ****************************************************************
  // configuration state
  // ****************************************************************
  logic       report_en, next_report_en;
  logic [1:0] off_cond, next_off_cond;
  logic [3:0] tmo_code, next_tmo_code;
  logic       invert, next_invert;
  logic       cmd_status, cmd_done;

  always_comb begin
    next_report_en = report_en;
    next_off_cond  = off_cond;
    next_tmo_code  = tmo_code;
    next_invert    = invert;
    cmd_status     = 1'h0;
    cmd_done       = 1'h0;
    // a load and a command in one cycle touch different fields, so both land
    if (CFG_LOAD_IN) begin
      next_tmo_code = CFG_TMO_CODE_IN;
      next_invert   = CFG_INVERT_IN;
    end
    if (CMD_IN.valid) begin
      unique case (CMD_IN.code)
        `PSC_CMD_STATUS: cmd_status = 1'h1;
        `PSC_CMD_RPT_ON: begin
          next_report_en = 1'h1;
          cmd_done       = 1'h1;
        end
        `PSC_CMD_RPT_OFF: begin
          next_report_en = 1'h0;
          cmd_done       = 1'h1;
        end
        `PSC_CMD_OFF_TMO: begin
          next_off_cond = `PSC_OFF_TMO;
          cmd_done      = 1'h1;
        end
        `PSC_CMD_OFF_TAG: begin
          next_off_cond = `PSC_OFF_TAG;
          cmd_done      = 1'h1;
        end
        `PSC_CMD_OFF_PRES: begin
          next_off_cond = `PSC_OFF_PRES;
          cmd_done      = 1'h1;
        end
        default: begin
          cmd_done = 1'h0;
        end
      endcase
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      report_en <= `PSC_RPT_RST;
      off_cond  <= `PSC_OFF_RST;
      tmo_code  <= `PSC_TMO_RST;
      invert    <= `PSC_INV_RST;
    end else begin
      report_en <= next_report_en;
      off_cond  <= next_off_cond;
      tmo_code  <= next_tmo_code;
      invert    <= next_invert;
    end
  end

  // ****************************************************************
  // field packing
  // ****************************************************************
  // every reply field is one hex digit; narrower settings are zero padded
  function automatic logic [3:0] digit(input logic [1:0] v);
    return {2'h0, v};
  endfunction

  // ****************************************************************
  // reply
  // ****************************************************************
  // reply shows the settings as they stood when the query was taken
  psc_pkg::psc_status_s next_status;
  logic                 next_reply_valid;
  psc_pkg::psc_kind_e   next_kind;

  always_comb begin
    next_status            = REPLY_STATUS_OUT;
    next_reply_valid       = cmd_status | cmd_done;
    next_kind              = REPLY_KIND_OUT;
    if (cmd_status) begin
      next_kind              = psc_pkg::KIND_STATUS;
      next_status.report     = digit({1'h0, report_en});
      next_status.min_period = `PSC_MIN_PRES_MS;
      next_status.rf_off     = digit(off_cond);
      next_status.timeout    = tmo_code;
      next_status.invert     = digit({1'h0, invert});
    end else if (cmd_done) begin
      next_kind              = psc_pkg::KIND_DONE;
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      REPLY_VALID_OUT  <= 1'h0;
      REPLY_KIND_OUT   <= psc_pkg::KIND_STATUS;
      REPLY_STATUS_OUT <= '0;
    end else begin
      REPLY_VALID_OUT  <= next_reply_valid;
      REPLY_KIND_OUT   <= next_kind;
      REPLY_STATUS_OUT <= next_status;
    end
  end

  // ****************************************************************
  // presence and rf-off
  // ****************************************************************
  logic pres, pres_d, rf_d;
  logic next_pres_report;
  logic next_rf_off_req;
  logic single;
  logic expired;

  // zero minimum period: presence is reported on the first true sample
  assign pres   = pres_sync ^ invert;
  assign single = (MODE_IN == psc_pkg::MODE_TRUCK);

  psc_rftmo #(
    .MS_CYCLES   (MS_CYCLES)
  ) u_tmo (
    .clk         (CORE_CLK_IN),
    .rstn        (RSTN_IN),
    .start_in    (RF_ON_IN & ~rf_d),
    .stop_in     (~RF_ON_IN & rf_d),
    .code_in     (tmo_code),
    .single_in   (single),
    .expired_out (expired)
  );

  // the request follows rf-on, so it drops as soon as rf is turned off
  always_comb begin
    next_pres_report = report_en & pres & ~pres_d & ~TAG_READ_IN;
    next_rf_off_req  = 1'h0;
    if (RF_ON_IN) begin
      unique case (off_cond)
        `PSC_OFF_TAG:  next_rf_off_req = expired | TAG_READ_IN;
        `PSC_OFF_PRES: next_rf_off_req = expired | ~pres;
        default:       next_rf_off_req = expired;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      pres_d              <= 1'h0;
      rf_d                <= 1'h0;
      PRESENCE_OUT        <= 1'h0;
      PRESENCE_REPORT_OUT <= 1'h0;
      RF_OFF_REQ_OUT      <= 1'h0;
    end else begin
      pres_d              <= pres;
      rf_d                <= RF_ON_IN;
      PRESENCE_OUT        <= pres;
      PRESENCE_REPORT_OUT <= next_pres_report;
      RF_OFF_REQ_OUT      <= next_rf_off_req;
    end
  end

endmodule

// ===== shared/psc_regs.svh
// Purpose : constants for the presence status command handler
// Assumes : 20 MHz core clock
// Notes   : command codes are the decimal digits packed one per nibble
`ifndef PSC_REGS_SVH
`define PSC_REGS_SVH

// ****************************************************************
// command codes
// ****************************************************************
`define PSC_CMD_STATUS      16'h0529
`define PSC_CMD_RPT_OFF     16'h6900
`define PSC_CMD_RPT_ON      16'h6901
`define PSC_CMD_OFF_TMO     16'h6920
`define PSC_CMD_OFF_TAG     16'h6921
`define PSC_CMD_OFF_PRES    16'h6922

// ****************************************************************
// field encodings and reset values
// ****************************************************************
`define PSC_RPT_RST         1'h0
`define PSC_MIN_PRES_MS     4'h0
`define PSC_OFF_TMO         2'h0
`define PSC_OFF_TAG         2'h1
`define PSC_OFF_PRES        2'h2
`define PSC_OFF_RST         2'h0
`define PSC_TMO_ZERO        4'h0
`define PSC_TMO_INF         4'hF
`define PSC_TMO_RST         4'hF
`define PSC_INV_RST         1'h0

// ****************************************************************
// timing
// ****************************************************************
`define PSC_CLK_HZ          20000000
`define PSC_TICK_MS         1
`define PSC_MS_CYCLES       ((`PSC_CLK_HZ / 1000) * `PSC_TICK_MS)
`define PSC_MS_W            11
`define PSC_T1_MS           11'h030
`define PSC_T1_SGL_MS       11'h096
`define PSC_T8_MS           11'h03C
`define PSC_T8_SGL_MS       11'h0AF
`define PSC_T9_MS           11'h05C
`define PSC_T9_SGL_MS       11'h0AF
`define PSC_TA_MS           11'h098
`define PSC_TA_SGL_MS       11'h172
`define PSC_TB_MS           11'h1C4
`define PSC_TB_SGL_MS       11'h2A8
`define PSC_TC_MS           11'h1C4
`define PSC_TC_SGL_MS       11'h3E8
`define PSC_TD_MS           11'h1F4
`define PSC_TD_SGL_MS       11'h3E8
`define PSC_TE_MS           11'h208
`define PSC_TE_SGL_MS       11'h5DC

`endif

// ===== shared/psc_pkg.sv
// Purpose : types of the presence status command handler
// Assumes : constants live in psc_regs.svh
// Notes   : reply fields are one hex digit each, in reply order
package psc_pkg;

  typedef enum logic [2:0] {
    MODE_ID       = 3'h0,
    MODE_EXT      = 3'h1,
    MODE_DUAL1    = 3'h2,
    MODE_DUAL2    = 3'h3,
    MODE_TRUCK    = 3'h4
  } psc_mode_e;

  typedef enum logic [1:0] {
    KIND_STATUS   = 2'h0,
    KIND_DONE     = 2'h1
  } psc_kind_e;

  typedef enum logic [1:0] {
    TMO_IDLE      = 2'h0,
    TMO_RUN       = 2'h1,
    TMO_DONE      = 2'h2
  } psc_tmo_e;

  typedef struct packed {
    logic        valid;
    logic [15:0] code;
  } psc_cmd_s;

  typedef struct packed {
    logic [3:0] report;
    logic [3:0] min_period;
    logic [3:0] rf_off;
    logic [3:0] timeout;
    logic [3:0] invert;
  } psc_status_s;

endpackage

// ===== verilog/psc_rftmo.sv
// Purpose : rf timeout timer with mode dependent lookup
// Assumes : start and stop are same-clock levels' edges from the top
// Notes   : millisecond tick from a divider, one clock only
`include "psc_regs.svh"

module psc_rftmo #(
  parameter int MS_CYCLES = `PSC_MS_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       start_in,
  input  wire logic       stop_in,
  input  wire logic [3:0] code_in,
  input  wire logic       single_in,
  output logic            expired_out
);

  localparam int DW = $clog2(MS_CYCLES + 1);

  // ****************************************************************
  // lookup
  // ****************************************************************
  function automatic logic [`PSC_MS_W-1:0] ms_of(input logic [3:0] c, input logic s);
    logic [`PSC_MS_W-1:0] v;
    v = `PSC_T1_MS;
    unique case (c)
      4'h8:    v = s ? `PSC_T8_SGL_MS : `PSC_T8_MS;
      4'h9:    v = s ? `PSC_T9_SGL_MS : `PSC_T9_MS;
      4'hA:    v = s ? `PSC_TA_SGL_MS : `PSC_TA_MS;
      4'hB:    v = s ? `PSC_TB_SGL_MS : `PSC_TB_MS;
      4'hC:    v = s ? `PSC_TC_SGL_MS : `PSC_TC_MS;
      4'hD:    v = s ? `PSC_TD_SGL_MS : `PSC_TD_MS;
      4'hE:    v = s ? `PSC_TE_SGL_MS : `PSC_TE_MS;
      default: v = s ? `PSC_T1_SGL_MS : `PSC_T1_MS;
    endcase
    return v;
  endfunction

  // ****************************************************************
  // timer
  // ****************************************************************
  psc_pkg::psc_tmo_e          state, next_state;
  logic [DW-1:0]              div, next_div;
  logic [`PSC_MS_W-1:0]       left, next_left;
  logic                       inf, next_inf;
  logic                       tick;

  assign tick = (div == DW'(MS_CYCLES - 1));

  always_comb begin
    next_state = state;
    next_div   = tick ? '0 : div + DW'(1);
    next_left  = left;
    next_inf   = inf;
    unique case (state)
      psc_pkg::TMO_IDLE: begin
        next_div = '0;
      end
      psc_pkg::TMO_RUN: begin
        if (tick && !inf) begin
          next_left = left - `PSC_MS_W'(1);
          if (left == `PSC_MS_W'(1)) begin
            next_state = psc_pkg::TMO_DONE;
          end
        end
      end
      psc_pkg::TMO_DONE: begin
        next_div = '0;
      end
      default: next_state = psc_pkg::TMO_IDLE;
    endcase
    if (start_in) begin
      next_div  = '0;
      next_left = ms_of(code_in, single_in);
      next_inf  = (code_in == `PSC_TMO_INF);
      // zero code is expired from the start
      next_state = (code_in == `PSC_TMO_ZERO) ? psc_pkg::TMO_DONE : psc_pkg::TMO_RUN;
    end else if (stop_in) begin
      next_state = psc_pkg::TMO_IDLE;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state       <= psc_pkg::TMO_IDLE;
      div         <= '0;
      left        <= '0;
      inf         <= 1'h0;
      expired_out <= 1'h0;
    end else begin
      state       <= next_state;
      div         <= next_div;
      left        <= next_left;
      inf         <= next_inf;
      expired_out <= (next_state == psc_pkg::TMO_DONE);
    end
  end

endmodule

// ===== tb/psc_host.sv
// Purpose : host side model that issues decoded reader commands
// Assumes : one command per cycle with go high, launched on the next edge
// Notes   : idle code toggles so a stale code never looks valid
module psc_host (
  input  wire logic         clk_in,
  input  wire logic         rstn_in,
  input  wire logic         go_in,
  input  wire logic [15:0]  code_in,
  output psc_pkg::psc_cmd_s cmd_out
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cmd_out <= '0;
    end else begin
      cmd_out.valid <= go_in;
      cmd_out.code  <= go_in ? code_in : ~cmd_out.code;
    end
  end
endmodule

// ===== tb/psc_top_sva.sv
// Purpose : reply checks of the presence status command handler
// Assumes : commands are taken on the edge where valid is high
// Notes   : timer lengths are left to the bench, too long for here
`include "psc_regs.svh"
module psc_top_sva #(
  parameter int MS_CYCLES = 4
) (
  input wire logic                 CORE_CLK_IN,
  input wire logic                 RSTN_IN,
  input wire psc_pkg::psc_cmd_s    CMD_IN,
  input wire logic                 CFG_LOAD_IN,
  input wire logic [3:0]           CFG_TMO_CODE_IN,
  input wire logic                 CFG_INVERT_IN,
  input wire logic                 REPLY_VALID_OUT,
  input wire psc_pkg::psc_kind_e   REPLY_KIND_OUT,
  input wire psc_pkg::psc_status_s REPLY_STATUS_OUT,
  input wire logic                 RF_OFF_REQ_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RSTN_IN);
  logic st;
  logic dn;
  assign st = REPLY_VALID_OUT && REPLY_KIND_OUT == psc_pkg::KIND_STATUS;
  assign dn = REPLY_VALID_OUT && REPLY_KIND_OUT == psc_pkg::KIND_DONE;
  // the command is passed in, so the check sees its sampled value
  function automatic logic is(input psc_pkg::psc_cmd_s m, input logic [15:0] c);
    is = m.valid && m.code == c;
  endfunction
  property p_status; is(CMD_IN, `PSC_CMD_STATUS) |=> st; endproperty
  property p_min; st |-> REPLY_STATUS_OUT.min_period == `PSC_MIN_PRES_MS; endproperty
  property p_fields;
    st |-> REPLY_STATUS_OUT.rf_off <= 4'h2 && REPLY_STATUS_OUT.report <= 4'h1;
  endproperty
  property p_on; is(CMD_IN, `PSC_CMD_RPT_ON) |=> dn; endproperty
  property p_on_seen;
    is(CMD_IN, `PSC_CMD_RPT_ON) ##1 is(CMD_IN, `PSC_CMD_STATUS) |=>
      REPLY_STATUS_OUT.report == 4'h1;
  endproperty
  property p_off_seen;
    is(CMD_IN, `PSC_CMD_RPT_OFF) ##1 is(CMD_IN, `PSC_CMD_STATUS) |=>
      REPLY_STATUS_OUT.report == 4'h0;
  endproperty
  property p_sel;
    is(CMD_IN, `PSC_CMD_OFF_TMO) || is(CMD_IN, `PSC_CMD_OFF_TAG) ||
      is(CMD_IN, `PSC_CMD_OFF_PRES) |=> dn;
  endproperty
  property p_sel_seen;
    is(CMD_IN, `PSC_CMD_OFF_TAG) ##1 is(CMD_IN, `PSC_CMD_STATUS) |=>
      REPLY_STATUS_OUT.rf_off == 4'h1;
  endproperty
  // a load one cycle ahead of the query must already show in the reply
  property p_cfg;
    CFG_LOAD_IN ##1 (is(CMD_IN, `PSC_CMD_STATUS) && !CFG_LOAD_IN) |=>
      REPLY_STATUS_OUT.timeout == $past(CFG_TMO_CODE_IN, 2) &&
      REPLY_STATUS_OUT.invert == {3'h0, $past(CFG_INVERT_IN, 2)};
  endproperty
  a_status:   assert property (p_status) else $error("no status reply");
  a_min:      assert property (p_min) else $error("min period not zero");
  a_fields:   assert property (p_fields) else $error("field out of range");
  a_on:       assert property (p_on) else $error("no done after enable");
  a_on_seen:  assert property (p_on_seen) else $error("report not on");
  a_off_seen: assert property (p_off_seen) else $error("report not off");
  a_sel:      assert property (p_sel) else $error("no done after rf-off select");
  a_sel_seen: assert property (p_sel_seen) else $error("rf-off field wrong");
  a_cfg:      assert property (p_cfg) else $error("loaded config not shown");
  c_status: cover property (st);
  c_done:   cover property (dn);
  c_rfoff:  cover property ($rose(RF_OFF_REQ_OUT));
endmodule
bind psc_top psc_top_sva #(.MS_CYCLES(MS_CYCLES)) u_sva (
  .CORE_CLK_IN(CORE_CLK_IN), .RSTN_IN(RSTN_IN), .CMD_IN(CMD_IN),
  .CFG_LOAD_IN(CFG_LOAD_IN), .CFG_TMO_CODE_IN(CFG_TMO_CODE_IN),
  .CFG_INVERT_IN(CFG_INVERT_IN), .REPLY_VALID_OUT(REPLY_VALID_OUT),
  .REPLY_KIND_OUT(REPLY_KIND_OUT), .REPLY_STATUS_OUT(REPLY_STATUS_OUT),
  .RF_OFF_REQ_OUT(RF_OFF_REQ_OUT));

// ===== tb/tb_presence_status_command_handler.sv
// Purpose : self checking bench of the presence status command handler
// Assumes : ms divider shortened to 4 cycles
// Notes   : tag read pulses only in the rf-off on tag scenario
`include "psc_regs.svh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin err_total++; \
  $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module tb_presence_status_command_handler;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MSC = 4;
  logic clk = 0, rstn = 0, go = 0, pin = 0, rf_on = 0, ld = 0, inv = 0, tag = 0, got;
  logic [15:0] code = 16'h0000;
  logic [3:0] tcode = 4'h0;
  psc_pkg::psc_mode_e mode = psc_pkg::MODE_ID;
  psc_pkg::psc_cmd_s cmd;
  psc_pkg::psc_kind_e rk;
  psc_pkg::psc_status_s rs;
  logic rv, pres, prpt, rfreq;
  int err_total = 0, total_checks = 0;
  int tc[6] = '{0, 1, 7, 8, 9, 10};
  int mi[6] = '{0, 48, 48, 60, 92, 152};
  int mt[6] = '{0, 150, 150, 175, 175, 370};
  psc_host u_host (.clk_in(clk), .rstn_in(rstn), .go_in(go), .code_in(code), .cmd_out(cmd));
  psc_top #(.MS_CYCLES(MSC)) DUT (
    .CORE_CLK_IN(clk), .RSTN_IN(rstn), .CMD_IN(cmd), .MODE_IN(mode),
    .PRESENCE_PIN_IN(pin), .TAG_READ_IN(tag), .RF_ON_IN(rf_on), .CFG_LOAD_IN(ld),
    .CFG_TMO_CODE_IN(tcode), .CFG_INVERT_IN(inv), .REPLY_VALID_OUT(rv),
    .REPLY_KIND_OUT(rk), .REPLY_STATUS_OUT(rs), .PRESENCE_OUT(pres),
    .PRESENCE_REPORT_OUT(prpt), .RF_OFF_REQ_OUT(rfreq));
  initial begin
    forever #25 clk = ~clk;
  end
  task end_sim;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task send(input logic [15:0] c);
    @(posedge clk); go <= 1'b1; code <= c;
  endtask
  task idle;
    @(posedge clk); go <= 1'b0;
  endtask
  task wait_rep;
    got = 1'b0;
    repeat (8) begin
      @(posedge clk); #1;
      if (rv === 1'b1) begin got = 1'b1; break; end
    end
  endtask
  // second reply of a back-to-back pair lands one cycle after the first
  task pair(input logic [15:0] c);
    send(c); send(`PSC_CMD_STATUS); idle(); #1;
    `CHK("first", 1'b1, rv)
    `CHK("done", psc_pkg::KIND_DONE, rk)
    @(posedge clk); #1;
    `CHK("second", 1'b1, rv)
    `CHK("second kind", psc_pkg::KIND_STATUS, rk)
  endtask
  task t_defaults;
    send(`PSC_CMD_STATUS); idle(); wait_rep();
    `CHK("kind", psc_pkg::KIND_STATUS, rk)
    `CHK("reset status", 20'h000F0, rs)
  endtask
  task t_report;
    pair(`PSC_CMD_RPT_ON);
    `CHK("report on", 4'h1, rs.report)
    pair(`PSC_CMD_RPT_OFF);
    `CHK("report off", 4'h0, rs.report)
    send(16'h0521); idle(); wait_rep();
    `CHK("foreign code", 1'b0, got)
  endtask
  task t_rfoff;
    for (int i = 0; i < 3; i++) begin
      pair(`PSC_CMD_OFF_TMO + 16'(i));
      `CHK("rf-off", i[3:0], rs.rf_off)
    end
    pair(`PSC_CMD_OFF_TMO);
  endtask
  // ms below zero means the request must never come
  task t_tmo(input logic [3:0] c, input psc_pkg::psc_mode_e m, input int ms);
    int n;
    @(posedge clk); ld <= 1'b1; tcode <= c; mode <= m;
    @(posedge clk); ld <= 1'b0; rf_on <= 1'b1;
    n = 0;
    while (rfreq !== 1'b1 && n < 2000) begin
      @(posedge clk); #1; n++;
    end
    `CHK("timeout", 1'b1, ms < 0 ? n == 2000 : n >= ms * MSC && n <= ms * MSC + 6)
    @(posedge clk); rf_on <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task t_tag;
    pair(`PSC_CMD_OFF_TAG);
    @(posedge clk); rf_on <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    `CHK("no tag no off", 1'b0, rfreq)
    @(posedge clk); tag <= 1'b1;
    @(posedge clk); tag <= 1'b0;
    #1;
    `CHK("off on tag", 1'b1, rfreq)
    @(posedge clk); rf_on <= 1'b0;
  endtask
  task t_pres;
    send(`PSC_CMD_RPT_ON); send(`PSC_CMD_OFF_PRES); idle(); wait_rep();
    @(posedge clk); rf_on <= 1'b1;
    repeat (5) @(posedge clk);
    #1;
    `CHK("off on no presence", 1'b1, rfreq)
    @(posedge clk); pin <= 1'b1;
    got = 1'b0;
    repeat (8) begin
      @(posedge clk); #1;
      if (prpt === 1'b1) got = 1'b1;
    end
    `CHK("presence report", 1'b1, got)
    `CHK("presence back", 1'b0, rfreq)
    `CHK("presence out", 1'b1, pres)
    @(posedge clk); rf_on <= 1'b0; pin <= 1'b0;
  endtask
  task t_cfg;
    @(posedge clk); ld <= 1'b1; tcode <= 4'h8; inv <= 1'b1; go <= 1'b1;
    code <= `PSC_CMD_STATUS;
    @(posedge clk); ld <= 1'b0; go <= 1'b0;
    wait_rep();
    `CHK("timeout code", 4'h8, rs.timeout)
    `CHK("invert", 4'h1, rs.invert)
    `CHK("inverted presence", 1'b1, pres)
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    end_sim();
  end
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    t_defaults();
    t_report();
    t_rfoff();
    for (int k = 0; k < 6; k++) begin
      t_tmo(tc[k][3:0], psc_pkg::MODE_ID, mi[k]);
      t_tmo(tc[k][3:0], psc_pkg::MODE_TRUCK, mt[k]);
    end
    t_tmo(4'h8, psc_pkg::MODE_DUAL2, 60);
    t_tmo(4'hF, psc_pkg::MODE_ID, -1);
    t_tag();
    t_pres();
    t_cfg();
    end_sim();
  end
endmodule
